// [src/pos_pkg.sv]
// constants, types and register map of the power-on/off sequencer
//------------------------------------------------------------------
// Notes on behaviour
// - debounced button follows a falling edge after 50 ms, a rising edge at once
// - buck start order comes from the programmable converter sequence setting
// - bucks in the same start-up group start in the same step
// - each buck enable rises when its group starts ramping
// - power good only when every masked rail reports regulation
// - usb supply counts exactly like adapter supply for power-on decisions
// - the two linear regulators start with, after or before the bucks per setting
// - stand-by keeps all bucks and the system rail off
// - stand-by is left while adapter or usb supply is present
// - decision lasts one clock cycle, then wait-for-power-on (external) or power-on-1 (battery)
// - power-on-1 holds only while the button stays pressed low
// - hold-on request high moves power-on-1 to power-on-2
// - in power-on-2 only the hold-on request decides power-off
// - adapter and usb behave alike; battery alone takes its own path
// - powering off drops power good at once, ramps down reversed, rail last, then stand-by
// - on battery only a button falling edge leaves stand-by; hold-on is ignored
// - power-on-1 ramps the system rail first, settles, then starts groups in order
//------------------------------------------------------------------
package pos_pkg;

    //------------------------------------------------------------------
    // timing
    //------------------------------------------------------------------
    localparam int CLK_HZ       = 40_000_000;
    localparam int DEBOUNCE_MS  = 50;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int STEP_US      = 1000;
    localparam int STEP_CYC     = STEP_US * (CLK_HZ / 1_000_000);

    //------------------------------------------------------------------
    // register map
    //------------------------------------------------------------------
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] ADDR_CONFIG  = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    localparam int CFG_SEQ_LSB   = 0;
    localparam int CFG_ORDER_LSB = 4;
    localparam int CFG_MASK_LSB  = 8;

    localparam int ST_STATE_LSB = 0;
    localparam int ST_LEVEL_LSB = 3;
    localparam int ST_POWER_GOOD_FLAG     = 6;
    localparam int ST_BTN       = 7;
    localparam int ST_EXT       = 8;
    localparam int ST_HOLD      = 9;
    localparam int ST_SYS       = 10;

    localparam int IRQ_N        = 4;
    localparam int IRQ_POWER_GOOD_FLAG    = 0;
    localparam int IRQ_POFF     = 1;
    localparam int IRQ_STANDBY  = 2;
    localparam int IRQ_PRESS    = 3;

    //------------------------------------------------------------------
    // pins and sequencing
    //------------------------------------------------------------------
    localparam int         PIN_N      = 9;
    localparam int         PIN_BTN    = 0;
    localparam int         PIN_HOLD   = 1;
    localparam int         PIN_ADAPT  = 2;
    localparam int         PIN_USB    = 3;
    localparam int         PIN_BUCK   = 4;
    localparam int         PIN_LIN    = 7;
    localparam logic [8:0] PIN_RST    = 9'h001;

    localparam logic [1:0] ORDER_WITH   = 2'h0;
    localparam logic [1:0] ORDER_AFTER  = 2'h1;
    localparam logic [1:0] ORDER_BEFORE = 2'h2;

    localparam logic [2:0] SLOT_BEFORE = 3'h0;
    localparam logic [2:0] SLOT_GRP_X  = 3'h1;
    localparam logic [2:0] SLOT_GRP_Y  = 3'h2;
    localparam logic [2:0] SLOT_AFTER  = 3'h3;
    localparam logic [2:0] LVL_OFF     = 3'h0;
    localparam logic [2:0] LVL_SYS     = 3'h1;
    localparam logic [2:0] LVL_FULL    = 3'h5;
    localparam logic [2:0] LVL_SLOT0   = 3'h2;

    typedef enum logic [2:0] {
        ST_STANDBY  = 3'b000,
        ST_DECISION = 3'b001,
        ST_WAIT_PON = 3'b010,
        ST_PON1     = 3'b011,
        ST_PON2     = 3'b100,
        ST_POFF     = 3'b101
    } pos_state_e;

    typedef struct packed {
        logic [4:0] mask;
        logic [1:0] order;
        logic [2:0] seq;
    } pos_cfg_s;

    localparam pos_cfg_s CFG_RST = '{mask: 5'h07, order: 2'h0, seq: 3'h4};

endpackage : pos_pkg

// [src/pos_sequencer.sv]
// power-on/off sequencer with axi4-lite register slave
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module pos_sequencer
    import pos_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int STEP_CYCLES     = STEP_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              button_in_n,
    input  wire logic              hold_on_req,
    input  wire logic              adapter_present,
    input  wire logic              usb_present,
    input  wire logic [2:0]        buck_in_regulation,
    input  wire logic [1:0]        linreg_in_regulation,
    output logic                   button_debounced_out,
    output logic                   system_rail,
    output logic                   buck1_enable,
    output logic                   buck2_enable,
    output logic                   buck3_enable,
    output logic                   linreg1_enable,
    output logic                   linreg2_enable,
    output logic                   power_good_flag,
    output logic                   irq
);

    //------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] sync1_reg;
    logic [PIN_N-1:0] sync2_reg;
    logic [PIN_N-1:0] sync3_reg;
    logic [PIN_N-1:0] pin_reg;

    assign pin_raw = {linreg_in_regulation, buck_in_regulation, usb_present,
                      adapter_present, hold_on_req, button_in_n};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_reg[gi] <= PIN_RST[gi];
                    sync2_reg[gi] <= PIN_RST[gi];
                    sync3_reg[gi] <= PIN_RST[gi];
                    pin_reg[gi]   <= PIN_RST[gi];
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        pin_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    logic       btn_n;
    logic       hold_on;
    logic       ext_power;
    logic [4:0] rail_ok;

    assign btn_n     = pin_reg[PIN_BTN];
    assign hold_on   = pin_reg[PIN_HOLD];
    assign ext_power = pin_reg[PIN_ADAPT] | pin_reg[PIN_USB];
    assign rail_ok   = {pin_reg[PIN_LIN+1:PIN_LIN], pin_reg[PIN_BUCK+2:PIN_BUCK]};

    //------------------------------------------------------------------
    // button debounce
    //------------------------------------------------------------------
    logic        btn_prev_reg;
    logic        btn_fall;
    logic        deb_reg;
    logic        deb_next;
    logic [31:0] deb_cnt_reg;

    assign btn_fall = btn_prev_reg & ~btn_n;

    always_comb begin
        deb_next = deb_reg;
        if (btn_n) begin
            deb_next = 1'b1;
        end else if (deb_cnt_reg == 32'(DEBOUNCE_CYCLES - 1)) begin
            deb_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            btn_prev_reg <= 1'b1;
            deb_reg      <= 1'b1;
            deb_cnt_reg  <= 32'h0;
        end else begin
            btn_prev_reg <= btn_n;
            deb_reg      <= deb_next;
            if (btn_n || !deb_reg) begin
                deb_cnt_reg <= 32'h0;
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 32'h1;
            end
        end
    end

    //------------------------------------------------------------------
    // state machine
    //------------------------------------------------------------------
    pos_state_e  state_reg;
    pos_state_e  state_next;
    logic [2:0]  level_reg;
    logic [31:0] step_cnt_reg;
    logic        step_done;
    logic        powering_up;

    assign step_done   = step_cnt_reg == 32'(STEP_CYCLES - 1);
    assign powering_up = (state_reg == ST_PON1) || (state_reg == ST_PON2);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_STANDBY: begin
                if (ext_power || btn_fall) begin
                    state_next = ST_DECISION;
                end
            end
            ST_DECISION: begin
                state_next = ext_power ? ST_WAIT_PON : ST_PON1;
            end
            ST_WAIT_PON: begin
                if (hold_on) begin
                    state_next = ST_PON2;
                end else if (!ext_power) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_PON1: begin
                if (hold_on) begin
                    state_next = ST_PON2;
                end else if (btn_n) begin
                    state_next = ST_POFF;
                end
            end
            ST_PON2: begin
                if (!hold_on) begin
                    state_next = ST_POFF;
                end
            end
            ST_POFF: begin
                if (level_reg == LVL_OFF) begin
                    state_next = ST_STANDBY;
                end
            end
            default: begin
                state_next = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_STANDBY;
        end else begin
            state_reg <= state_next;
        end
    end

    //------------------------------------------------------------------
    // ramp level: rail first, then slots in order, reversed on the way down
    //------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_reg    <= LVL_OFF;
            step_cnt_reg <= 32'h0;
        end else if (powering_up && level_reg != LVL_FULL) begin
            if (level_reg == LVL_OFF) begin
                level_reg    <= LVL_SYS;
                step_cnt_reg <= 32'h0;
            end else if (step_done) begin
                level_reg    <= level_reg + 3'h1;
                step_cnt_reg <= 32'h0;
            end else begin
                step_cnt_reg <= step_cnt_reg + 32'h1;
            end
        end else if (state_reg == ST_POFF && level_reg != LVL_OFF) begin
            if (step_done) begin
                level_reg    <= level_reg - 3'h1;
                step_cnt_reg <= 32'h0;
            end else begin
                step_cnt_reg <= step_cnt_reg + 32'h1;
            end
        end else begin
            step_cnt_reg <= 32'h0;
        end
    end

    //------------------------------------------------------------------
    // enables and power good
    //------------------------------------------------------------------
    pos_cfg_s   cfg_reg;
    logic [2:0] lin_slot;
    logic [4:0] en_next;
    logic       power_good_flag_next;

    always_comb begin
        case (cfg_reg.order)
            ORDER_AFTER:  lin_slot = SLOT_AFTER;
            ORDER_BEFORE: lin_slot = SLOT_BEFORE;
            default:      lin_slot = SLOT_GRP_X;
        endcase
    end

    generate
        for (gi = 0; gi < 3; gi++) begin : g_buck
            // one group bit per buck: all bucks with the same bit share a step
            assign en_next[gi] = level_reg >= ((cfg_reg.seq[gi] ? SLOT_GRP_Y : SLOT_GRP_X) + LVL_SLOT0);
        end
        for (gi = 3; gi < 5; gi++) begin : g_lin
            assign en_next[gi] = level_reg >= (lin_slot + LVL_SLOT0);
        end
    endgenerate

    assign power_good_flag_next = ((state_next == ST_PON1) || (state_next == ST_PON2))
                        && (level_reg == LVL_FULL)
                        && ((rail_ok | ~cfg_reg.mask) == 5'h1F);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_rail     <= 1'b0;
            buck1_enable    <= 1'b0;
            buck2_enable    <= 1'b0;
            buck3_enable    <= 1'b0;
            linreg1_enable  <= 1'b0;
            linreg2_enable  <= 1'b0;
            power_good_flag <= 1'b0;
        end else begin
            system_rail     <= level_reg >= LVL_SYS;
            buck1_enable    <= en_next[0];
            buck2_enable    <= en_next[1];
            buck3_enable    <= en_next[2];
            linreg1_enable  <= en_next[3];
            linreg2_enable  <= en_next[4];
            power_good_flag <= power_good_flag_next;
        end
    end

    assign button_debounced_out = deb_reg;

    //------------------------------------------------------------------
    // interrupts
    //------------------------------------------------------------------
    logic [IRQ_N-1:0] irq_stat_reg;
    logic [IRQ_N-1:0] irq_mask_reg;
    logic [IRQ_N-1:0] irq_event;
    logic [IRQ_N-1:0] irq_clr;

    always_comb begin
        irq_event              = '0;
        irq_event[IRQ_POWER_GOOD_FLAG]   = power_good_flag_next & ~power_good_flag;
        irq_event[IRQ_POFF]    = (state_next == ST_POFF) && (state_reg != ST_POFF);
        irq_event[IRQ_STANDBY] = (state_next == ST_STANDBY) && (state_reg != ST_STANDBY);
        irq_event[IRQ_PRESS]   = deb_reg & ~deb_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= '0;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
            irq          <= |(((irq_stat_reg & ~irq_clr) | irq_event) & irq_mask_reg);
        end
    end

    //------------------------------------------------------------------
    // axi4-lite write channel
    //------------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              aw_full_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              w_full_reg;
    logic              do_wr;
    logic [31:0]       strb_mask;
    logic [31:0]       cfg_word;
    logic [31:0]       cfg_word_new;

    assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign strb_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign cfg_word = {19'h0, cfg_reg.mask, 2'h0, cfg_reg.order, 1'b0, cfg_reg.seq};
    assign cfg_word_new = (cfg_word & ~strb_mask) | (w_data_reg & strb_mask);
    assign irq_clr = (do_wr && aw_addr_reg == ADDR_IRQ_ST) ? (w_data_reg[IRQ_N-1:0] & strb_mask[IRQ_N-1:0]) : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            aw_addr_reg   <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_wr) begin
            aw_full_reg <= 1'b0;
        end else if (!aw_full_reg && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg   <= 1'b0;
            w_data_reg   <= 32'h0;
            w_strb_reg   <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_wr) begin
            w_full_reg <= 1'b0;
        end else if (!w_full_reg && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr_reg)
                ADDR_CONFIG, ADDR_STATUS, ADDR_IRQ_ST, ADDR_IRQ_MSK: s_axi_bresp <= RESP_OKAY;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg      <= CFG_RST;
            irq_mask_reg <= '0;
        end else if (do_wr && aw_addr_reg == ADDR_CONFIG) begin
            cfg_reg.seq   <= cfg_word_new[CFG_SEQ_LSB+:3];
            cfg_reg.order <= cfg_word_new[CFG_ORDER_LSB+:2];
            cfg_reg.mask  <= cfg_word_new[CFG_MASK_LSB+:5];
        end else if (do_wr && aw_addr_reg == ADDR_IRQ_MSK) begin
            irq_mask_reg <= (irq_mask_reg & ~strb_mask[IRQ_N-1:0]) | (w_data_reg[IRQ_N-1:0] & strb_mask[IRQ_N-1:0]);
        end
    end

    //------------------------------------------------------------------
    // axi4-lite read channel
    //------------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    always_comb begin
        status_word = 32'h0;
        status_word[ST_STATE_LSB+:3] = state_reg;
        status_word[ST_LEVEL_LSB+:3] = level_reg;
        status_word[ST_POWER_GOOD_FLAG]        = power_good_flag;
        status_word[ST_BTN]          = deb_reg;
        status_word[ST_EXT]          = ext_power;
        status_word[ST_HOLD]         = hold_on;
        status_word[ST_SYS]          = system_rail;
    end

    always_comb begin
        rd_resp = RESP_OKAY;
        case (s_axi_araddr)
            ADDR_CONFIG:  rd_word = cfg_word;
            ADDR_STATUS:  rd_word = status_word;
            ADDR_IRQ_ST:  rd_word = {{(32-IRQ_N){1'b0}}, irq_stat_reg};
            ADDR_IRQ_MSK: rd_word = {{(32-IRQ_N){1'b0}}, irq_mask_reg};
            default: begin
                rd_word = 32'h0;
                rd_resp = RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_resp;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : pos_sequencer

// [tb/pos_checker.sv]
// assertion checker of the power sequencer
`timescale 1ns/1ps
module pos_checker #(
    parameter int DEBOUNCE_CYCLES = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic button_in_n,
    input wire logic hold_on_req,
    input wire logic adapter_present,
    input wire logic usb_present,
    input wire logic button_debounced_out,
    input wire logic system_rail,
    input wire logic buck1_enable,
    input wire logic buck2_enable,
    input wire logic buck3_enable,
    input wire logic power_good_flag
);
    logic [15:0] low_cnt;
    logic [7:0]  ext_cnt;
    wire logic   bk = buck1_enable | buck2_enable | buck3_enable;
    wire logic   ext = (adapter_present | usb_present) & !hold_on_req & button_in_n;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    //------------------------------------------------------------------
    // helper counters
    //------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || button_in_n) low_cnt <= '0;
        else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !ext) ext_cnt <= '0;
        else if (ext_cnt != 8'hFF) ext_cnt <= ext_cnt + 8'h01;
    end
    sequence s_rail_up;
        $rose(system_rail);
    endsequence
    sequence s_bucks_off;
        !bk;
    endsequence
    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    a_rails_off: assert property (!system_rail |-> !bk)
        else $error("buck enabled while rail off");
    a_rail_first: assert property (s_rail_up |-> s_bucks_off [*8])
        else $error("buck enabled too soon after rail");
    a_power_good_flag_full: assert property (power_good_flag |-> system_rail && buck1_enable && buck2_enable && buck3_enable)
        else $error("power good before full ramp");
    a_power_good_flag_drop: assert property ($fell(buck1_enable) || $fell(buck2_enable) || $fell(buck3_enable)
        |-> !power_good_flag)
        else $error("power good still high at ramp down");
    a_deb_rise: assert property (button_in_n [*7] |-> button_debounced_out)
        else $error("debounced button late on release");
    a_deb_fall: assert property ($fell(button_debounced_out) |-> low_cnt >= DEBOUNCE_CYCLES)
        else $error("debounced button fell early");
    a_deb_bound: assert property (low_cnt == DEBOUNCE_CYCLES + 8 |-> !button_debounced_out)
        else $error("debounced button never fell");
    a_ext_off: assert property (ext_cnt == 8'd100 |-> !system_rail)
        else $error("rail on without hold request");
endmodule : pos_checker

// [tb/pos_partner.sv]
// model of the push button and the application processor
`timescale 1ns/1ps
module pos_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic press,
    input wire logic arm,
    input wire logic force_hold,
    input wire logic power_good_flag,
    output logic     button_in_n = 1'b1,
    output logic     hold_on_req = 1'b0
);
    always_ff @(posedge aclk) begin
        button_in_n <= !press;
        if (!aresetn) hold_on_req <= 1'b0;
        else if (force_hold) hold_on_req <= 1'b1;
        else if (!arm) hold_on_req <= 1'b0;
        else if (power_good_flag) hold_on_req <= 1'b1;
    end
endmodule : pos_partner

// [tb/pos_sequencer_tb_top.sv]
// testbench of the power sequencer
`timescale 1ns/1ps
module pos_sequencer_tb_top;
    import pos_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, v;
    logic press = 0, arm = 0, fhold = 0, adapter = 0, usb = 0;
    logic [2:0]  breg = 3'h7;
    logic awr, wr_rdy, arr, bv, rv, bn, hold, dbn, rail, b1, b2, b3, l1, l2, pg, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    wire logic [6:0] pv = {pg, l2, l1, b3, b2, b1, rail};
    int err_total = 0, cmp_count = 0, cyc = 0;
    always #12.5 aclk = ~aclk;
    pos_partner PM (.aclk(aclk), .aresetn(aresetn), .press(press), .arm(arm), .force_hold(fhold),
        .power_good_flag(pg), .button_in_n(bn), .hold_on_req(hold));
    pos_sequencer #(.DEBOUNCE_CYCLES(20), .STEP_CYCLES(8)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .button_in_n(bn), .hold_on_req(hold), .adapter_present(adapter),
        .usb_present(usb), .buck_in_regulation(breg), .linreg_in_regulation(2'h3),
        .button_debounced_out(dbn), .system_rail(rail), .buck1_enable(b1), .buck2_enable(b2),
        .buck3_enable(b3), .linreg1_enable(l1), .linreg2_enable(l2), .power_good_flag(pg), .irq(irq));
    //------------------------------------------------------------------
    // tasks
    //------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wr_rdy) wv <= 0;
        end while (!(bv && bready));
        bready <= 0;
        chk(bresp, RESP_OKAY);
    endtask : wr
    task rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a; arv <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 0;
        end while (!(rv && rready));
        rready <= 0;
        v = rdata;
        chk(rresp, er);
    endtask : rd
    task wt(input int i, input logic val);
        while (pv[i] !== val) @(posedge aclk);
    endtask : wt
    task summarize;
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    //------------------------------------------------------------------
    // tests
    //------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        rd(ADDR_CONFIG, RESP_OKAY); chk(v, 32'h0000_0704);
        rd(8'h10, RESP_SLVERR); chk(v, 32'h0);
        wr(ADDR_IRQ_MSK, 32'h0000_000F);
        arm <= 1; press <= 1;
        wt(0, 1); wt(6, 1); repeat (10) @(posedge aclk);
        rd(ADDR_STATUS, RESP_OKAY); chk(v[2:0], 3'h4);
        chk(irq, 1'b1);
        rd(ADDR_IRQ_ST, RESP_OKAY); chk(v, 32'h0000_0009);
        wr(ADDR_IRQ_ST, 32'h0000_0009); repeat (2) @(posedge aclk); chk(irq, 1'b0);
        press <= 0; repeat (40) @(posedge aclk); chk(pg, 1'b1);
        arm <= 0; wt(0, 0);
        rd(ADDR_STATUS, RESP_OKAY); chk(v[2:0], 3'h0);
        rd(ADDR_IRQ_ST, RESP_OKAY); chk(v, 32'h0000_0006);
        fhold <= 1; repeat (40) @(posedge aclk); chk(rail, 1'b0);
        fhold <= 0; press <= 1; wt(0, 1); press <= 0; wt(0, 0);
        rd(ADDR_STATUS, RESP_OKAY); chk(v[2:0], 3'h0);
        wr(ADDR_CONFIG, 32'h0000_0721);
        for (int i = 0; i < 2; i++) begin
            adapter <= (i == 0); usb <= (i == 1); breg <= 3'h3;
            repeat (110) @(posedge aclk);
            rd(ADDR_STATUS, RESP_OKAY); chk(v[2:0], 3'h2);
            chk(rail, 1'b0);
            fhold <= 1; wt(4, 1); chk({l2, b3, b2, b1}, 4'h8);
            wt(2, 1); chk({b3, b2, b1}, 3'h6);
            wt(1, 1); repeat (20) @(posedge aclk); chk(pg, 1'b0);
            breg <= 3'h7; wt(6, 1);
            fhold <= 0; wt(0, 0); adapter <= 0; usb <= 0;
            repeat (9) @(posedge aclk);
        end
        summarize();
    end
endmodule : pos_sequencer_tb_top
bind pos_sequencer pos_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .button_in_n(button_in_n), .hold_on_req(hold_on_req), .adapter_present(adapter_present),
    .usb_present(usb_present), .button_debounced_out(button_debounced_out), .system_rail(system_rail),
    .buck1_enable(buck1_enable), .buck2_enable(buck2_enable), .buck3_enable(buck3_enable),
    .power_good_flag(power_good_flag));
